// >>> wpc_slave.sv
`timescale 1ns/1ps
`default_nettype none
module wpc_slave #(
  parameter int NUM_CH = 2                        // one or two wiper channels
) (
  input  wire  logic         mclk,                // system clock
  input  wire  logic         reset_n,             // synchronous reset, active low
  input  wire  logic         link_clk,            // bus sampling clock
  input  wire  logic         scl_in,              // serial clock pin level
  input  wire  logic         sda_in,              // serial data pin level
  output logic               sda_out,             // data pin drive value, always low
  output logic               sda_oe,              // high while pulling data low
  input  wire  logic         addr_pin_low_bit,    // address select pin, low bit
  input  wire  logic         addr_pin_high_bit,   // address select pin, high bit
  input  wire  logic         sleep_pin_low,       // shutdown pin, active low
  output logic               aux_out_one,         // latched aux output one
  output logic               aux_out_two,         // latched aux output two
  output logic               power_down_bit,      // latched software shutdown
  output logic [7:0]         wiper_channel_one,   // first wiper register
  output logic [7:0]         wiper_channel_two,   // second wiper register
  output logic [255:0]       tap_sel_one,         // one-hot tap select, first
  output logic [255:0]       tap_sel_two,         // one-hot tap select, second
  output logic               term_a_open,         // terminal A disconnected
  output logic               wiper_to_b           // wiper shorted to terminal B
);

  // refuse channel counts and tap widths the decode cannot serve
  if (NUM_CH < 1 || NUM_CH > 2) begin : g_bad_ch
    $error("NUM_CH must be 1 or 2");
  end
  if (wpc_pkg::NUM_TAPS != 256) begin : g_bad_taps
    $error("tap decode is built for 256 positions");
  end

  // ---------------- link domain ----------------
  logic       lrst_m_r, lrst_n_r;                 // reset brought into link domain
  logic       scl_m_r, scl_s_r, scl_q_r;          // clock pin synchroniser
  logic       sda_m_r, sda_s_r, sda_q_r;          // data pin synchroniser
  logic       ad0_m_r, ad0_s_r, ad1_m_r, ad1_s_r; // address pin synchronisers
  wpc_pkg::wpc_state_e state_r;
  logic [3:0] cnt_r;                              // bits seen in current byte
  logic [7:0] sh_r;                               // shift register
  logic       rd_ack_r;                           // master acked read byte
  logic [7:0] instr_r;                            // latched instruction byte
  logic [7:0] data_r;                             // latched data byte
  logic       apply_i_r, apply_d_r;               // one-cycle apply pulses
  logic [7:0] mir_r [2];                          // link-side wiper copies
  logic       sel_r;                              // channel chosen by last write
  logic       msd_r, mo1_r, mo2_r;                // link-side control copies
  logic       dirty_r;                            // copy changed, not yet sent
  logic       req_r;                              // transfer request toggle
  logic [7:0] bw_r [2];                           // bundle held for crossing
  logic       bsd_r, bo1_r, bo2_r;                // controls held for crossing
  logic       ack_m_r, ack_s_r;                   // returned acknowledge toggle
  logic       ack_r;                              // acknowledge toggle, system side

  // edge and condition detect on synchronised pins; start and stop need clock high on both samples
  wire rise  = scl_s_r & ~scl_q_r;
  wire fall  = ~scl_s_r & scl_q_r;
  wire start = scl_s_r & scl_q_r & sda_q_r & ~sda_s_r;
  wire stop  = scl_s_r & scl_q_r & ~sda_q_r & sda_s_r;
  wire byte_done = (cnt_r == wpc_pkg::BITS_PER_BYTE);
  wire chan  = (NUM_CH == 2) ? instr_r[wpc_pkg::INS_CHAN_BIT] : 1'b0;

  // reset and pin synchronisers; first flops feed only the second
  always_ff @(posedge link_clk) begin
    lrst_m_r <= reset_n;
    lrst_n_r <= lrst_m_r;
    scl_m_r  <= scl_in;
    scl_s_r  <= scl_m_r;
    scl_q_r  <= scl_s_r;
    sda_m_r  <= sda_in;
    sda_s_r  <= sda_m_r;
    sda_q_r  <= sda_s_r;
    ad0_m_r  <= addr_pin_low_bit;
    ad0_s_r  <= ad0_m_r;
    ad1_m_r  <= addr_pin_high_bit;
    ad1_s_r  <= ad1_m_r;
  end

  // address match against fixed bits and select pins
  function automatic logic addr_hit(input logic [7:0] b, input logic a1, input logic a0);
    addr_hit = (b[7:3] == wpc_pkg::ADDR_FIXED) && (b[2] == a1) && (b[1] == a0); // see RQ1 see RQ2
  endfunction

  // protocol engine: sample on SCL rise, drive on SCL fall
  always_ff @(posedge link_clk) begin
    apply_i_r <= 1'b0;
    apply_d_r <= 1'b0;
    if (!lrst_n_r) begin
      state_r  <= wpc_pkg::WPC_IDLE;
      cnt_r    <= 4'h0;
      sh_r     <= 8'h00;
      rd_ack_r <= 1'b0;
      instr_r  <= 8'h00;
      data_r   <= 8'h00;
      sda_oe   <= 1'b0;
    end else if (start) begin
      state_r <= wpc_pkg::WPC_ADDR;               // see RQ8 see RQ19
      cnt_r   <= 4'h0;
      sda_oe  <= 1'b0;
    end else if (stop) begin
      state_r <= wpc_pkg::WPC_IDLE;               // see RQ19
      sda_oe  <= 1'b0;
    end else begin
      unique case (state_r)
        // not addressed: keep the data pin released until the next start
        wpc_pkg::WPC_IDLE: begin
          sda_oe <= 1'b0;
        end
        // address, instruction and data bytes share one shifter
        wpc_pkg::WPC_ADDR, wpc_pkg::WPC_INSTR, wpc_pkg::WPC_DATA: begin
          if (rise && !byte_done) begin
            sh_r  <= {sh_r[6:0], sda_s_r};        // msb first, see RQ8
            cnt_r <= cnt_r + 4'h1;
          end else if (fall && byte_done) begin
            cnt_r <= 4'h0;
            if (state_r == wpc_pkg::WPC_ADDR) begin
              if (addr_hit(sh_r, ad1_s_r, ad0_s_r)) begin
                state_r <= wpc_pkg::WPC_ACK_A;
                sda_oe  <= 1'b1;                  // see RQ8 see RQ18
              end else begin
                state_r <= wpc_pkg::WPC_IDLE;
              end
            end else if (state_r == wpc_pkg::WPC_INSTR) begin
              instr_r <= sh_r;
              state_r <= wpc_pkg::WPC_ACK_I;
              sda_oe  <= 1'b1;                    // see RQ8
            end else begin
              data_r  <= sh_r;
              state_r <= wpc_pkg::WPC_ACK_D;
              sda_oe  <= 1'b1;                    // see RQ8
            end
          end
        end
        // ack slots: the pull ends on the fall that closes the ninth clock, except in a read whose first bit is low
        wpc_pkg::WPC_ACK_A: begin
          if (fall) begin
            if (sh_r[0]) begin
              state_r <= wpc_pkg::WPC_RD;         // see RQ3 see RQ9
              sh_r    <= mir_r[sel_r];
              sda_oe  <= ~mir_r[sel_r][7];        // see RQ18
            end else begin
              state_r <= wpc_pkg::WPC_INSTR;      // see RQ3
              sda_oe  <= 1'b0;
            end
          end
        end
        wpc_pkg::WPC_ACK_I: begin
          if (fall) begin
            apply_i_r <= 1'b1;                    // see RQ19
            state_r   <= wpc_pkg::WPC_DATA;
            sda_oe    <= 1'b0;
          end
        end
        wpc_pkg::WPC_ACK_D: begin
          if (fall) begin
            apply_d_r <= 1'b1;                    // see RQ11
            state_r   <= wpc_pkg::WPC_DATA;
            sda_oe    <= 1'b0;
          end
        end
        // read data: the next bit goes out on each clock fall
        wpc_pkg::WPC_RD: begin
          if (rise && !byte_done) begin
            cnt_r <= cnt_r + 4'h1;
          end else if (fall && byte_done) begin
            cnt_r   <= 4'h0;
            state_r <= wpc_pkg::WPC_RD_ACK;
            sda_oe  <= 1'b0;                      // release for master ack
          end else if (fall) begin
            sh_r   <= {sh_r[6:0], 1'b0};
            sda_oe <= ~sh_r[6];                   // see RQ18
          end
        end
        // master ack sends the byte again, nack ends the read
        wpc_pkg::WPC_RD_ACK: begin
          if (rise) begin
            rd_ack_r <= ~sda_s_r;
          end else if (fall) begin
            if (rd_ack_r) begin
              state_r <= wpc_pkg::WPC_RD;         // repeated read
              sh_r    <= mir_r[sel_r];
              sda_oe  <= ~mir_r[sel_r][7];
            end else begin
              state_r <= wpc_pkg::WPC_IDLE;       // nack, wait for stop, see RQ10
            end
          end
        end
      endcase
    end
  end

  // the pin is only ever pulled low; the enable alone carries the data
  assign sda_out = 1'b0;                          // open drain, see RQ18

  // link-side copies of wiper and control state
  always_ff @(posedge link_clk) begin
    if (!lrst_n_r) begin
      mir_r[0] <= wpc_pkg::MIDSCALE_CODE;         // see RQ14
      mir_r[1] <= wpc_pkg::MIDSCALE_CODE;
      sel_r    <= 1'b0;
      msd_r    <= 1'b0;
      mo1_r    <= 1'b0;
      mo2_r    <= 1'b0;
    end else if (apply_i_r) begin
      sel_r <= chan;                              // see RQ4 see RQ9
      msd_r <= instr_r[wpc_pkg::INS_SD_BIT];      // see RQ6
      mo1_r <= instr_r[wpc_pkg::INS_O1_BIT];      // see RQ7
      mo2_r <= instr_r[wpc_pkg::INS_O2_BIT];
      if (instr_r[wpc_pkg::INS_RS_BIT]) begin
        mir_r[chan] <= wpc_pkg::MIDSCALE_CODE;    // see RQ5
      end
    end else if (apply_d_r) begin
      mir_r[chan] <= data_r;                      // see RQ11
    end
  end

  // toggle handshake sending a full state snapshot to the system domain
  always_ff @(posedge link_clk) begin
    ack_m_r <= ack_r;
    ack_s_r <= ack_m_r;
    if (!lrst_n_r) begin
      dirty_r <= 1'b0;
      req_r   <= 1'b0;
      bw_r[0] <= wpc_pkg::MIDSCALE_CODE;
      bw_r[1] <= wpc_pkg::MIDSCALE_CODE;
      bsd_r   <= 1'b0;
      bo1_r   <= 1'b0;
      bo2_r   <= 1'b0;
    end else begin
      // snapshot only once the previous one has been taken
      if (dirty_r && (ack_s_r == req_r)) begin
        bw_r[0] <= mir_r[0];
        bw_r[1] <= mir_r[1];
        bsd_r   <= msd_r;
        bo1_r   <= mo1_r;
        bo2_r   <= mo2_r;
        req_r   <= ~req_r;
      end
      // a new change wins over the clear of the pending flag
      if (apply_i_r || apply_d_r) begin
        dirty_r <= 1'b1;
      end else if (dirty_r && (ack_s_r == req_r)) begin
        dirty_r <= 1'b0;
      end
    end
  end

  // ---------------- system domain ----------------
  logic       req_m_r, req_s_r;                   // request toggle synchroniser
  logic [7:0] wip_r [2];                          // applied wiper registers
  logic       sd_r, o1_r, o2_r;                   // applied controls
  logic [255:0] tap_r [2];                        // registered tap decode

  // capture the held snapshot once the request toggle has settled
  always_ff @(posedge mclk) begin
    req_m_r <= req_r;
    req_s_r <= req_m_r;
    if (!reset_n) begin
      ack_r  <= 1'b0;
      wip_r[0] <= wpc_pkg::MIDSCALE_CODE;         // see RQ14
      wip_r[1] <= wpc_pkg::MIDSCALE_CODE;
      sd_r   <= 1'b0;
      o1_r   <= 1'b0;
      o2_r   <= 1'b0;
    end else if (req_s_r != ack_r) begin
      ack_r    <= req_s_r;
      wip_r[0] <= bw_r[0];
      wip_r[1] <= bw_r[1];
      sd_r     <= bsd_r;                          // see RQ6
      o1_r     <= bo1_r;                          // see RQ7
      o2_r     <= bo2_r;
    end
  end

  // one-hot tap decode per channel; shutdown leaves registers untouched
  for (genvar c = 0; c < 2; c++) begin : g_tap
    always_ff @(posedge mclk) begin
      if (!reset_n) begin
        tap_r[c] <= 256'h1 << wpc_pkg::MIDSCALE_CODE;
      end else begin
        tap_r[c] <= 256'h1 << wip_r[c];           // see RQ15 see RQ16 see RQ13
      end
    end
  end

  // registered state straight to the ports
  assign wiper_channel_one = wip_r[0];
  assign wiper_channel_two = wip_r[1];
  assign tap_sel_one       = tap_r[0];
  assign tap_sel_two       = tap_r[1];
  assign aux_out_one       = o1_r;
  assign aux_out_two       = o2_r;
  assign power_down_bit    = sd_r;

  // shutdown path is combinational from the pin so it acts without a clock
  assign term_a_open = ~sleep_pin_low | sd_r;     // see RQ12 see RQ6
  assign wiper_to_b  = ~sleep_pin_low | sd_r;     // see RQ12 see RQ13

endmodule
`default_nettype wire

// >>> wpc_pkg.sv
// Contract
// RQ1: upper five address bits are fixed at 01011; master must send them.
// RQ2: respond only when the two low address bits match the sampled select pins.
// RQ3: direction bit high means read with device driving SDA; low means write.
// RQ4: instruction bit 7 selects wiper channel, 0 first and 1 second.
// RQ5: instruction bit 6 moves the selected wiper to midscale code 128.
// RQ6: instruction bit 5 is software shutdown, same as the sleep pin inverted.
// RQ7: instruction bits 4 and 3 latch onto the aux outputs; bits 2..0 ignored.
// RQ8: write frame is start, address, instruction, data msb first, stop; each byte acked.
// RQ9: read returns the wiper register last selected by a write; no instruction byte.
// RQ10: master leaves SDA high as nack after read data, then makes stop.
// RQ11: further data bytes under the same instruction update the selected wiper.
// RQ12: sleep pin opens terminal A and grounds wiper asynchronously, registers kept.
// RQ13: leaving shutdown reapplies the stored wiper setting.
// RQ14: every wiper register powers on at midscale 128.
// RQ15: wiper code decodes to exactly one of 256 taps; code zero is terminal B.
// RQ16: each code step moves one tap toward A; 255 is the last tap.
// RQ17: single channel master always sends channel select low.
// RQ18: device only pulls SDA low or releases it, changing it while SCL is low.
// RQ19: start or stop mid frame aborts; only acknowledged bytes take effect.
package wpc_pkg;
  localparam logic [4:0] ADDR_FIXED    = 5'h0b; // fixed upper address bits 01011
  localparam logic [7:0] MIDSCALE_CODE = 8'h80; // power-on and reset code
  localparam int         INS_CHAN_BIT  = 7;     // channel select
  localparam int         INS_RS_BIT    = 6;     // midscale reset
  localparam int         INS_SD_BIT    = 5;     // software shutdown
  localparam int         INS_O1_BIT    = 4;     // aux output one
  localparam int         INS_O2_BIT    = 3;     // aux output two
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;  // data bits before the ack slot
  localparam int         NUM_TAPS      = 256;   // tap positions per channel

  typedef enum logic [8:0] {
    WPC_IDLE   = 9'h001,
    WPC_ADDR   = 9'h002,
    WPC_ACK_A  = 9'h004,
    WPC_INSTR  = 9'h008,
    WPC_ACK_I  = 9'h010,
    WPC_DATA   = 9'h020,
    WPC_ACK_D  = 9'h040,
    WPC_RD     = 9'h080,
    WPC_RD_ACK = 9'h100
  } wpc_state_e;
endpackage

// >>> wpc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module wpc_monitor #(
  parameter int NUM_CH = 2                   // wiper channels
) (
  input wire logic         mclk,              // system clock
  input wire logic         reset_n,           // reset, active low
  input wire logic         link_clk,          // bus clock
  input wire logic         scl_in,            // serial clock
  input wire logic         sda_in,            // data wire
  input wire logic         sda_out,           // data drive value
  input wire logic         sda_oe,            // data pull enable
  input wire logic         addr_pin_low_bit,  // select pin low
  input wire logic         addr_pin_high_bit, // select pin high
  input wire logic         sleep_pin_low,     // shutdown pin
  input wire logic         aux_out_one,       // aux one
  input wire logic         aux_out_two,       // aux two
  input wire logic         power_down_bit,    // soft shutdown
  input wire logic [7:0]   wiper_channel_one, // wiper one
  input wire logic [7:0]   wiper_channel_two, // wiper two
  input wire logic [255:0] tap_sel_one,       // taps one
  input wire logic [255:0] tap_sel_two,       // taps two
  input wire logic         term_a_open,       // terminal a open
  input wire logic         wiper_to_b         // wiper at b
);
  // bus pin behaviour
  sda_drive_a: assert property (@(posedge link_clk) disable iff (!reset_n) sda_out == 1'b0)
    else $error("data pin driven high");
  sda_edge_a: assert property (@(posedge link_clk) disable iff (!reset_n) $changed(sda_oe) |-> !scl_in)
    else $error("data pull changed while clock high");
  ack_release_a: assert property (@(posedge link_clk) disable iff (!reset_n) $rose(sda_oe) |-> ##[1:100] !sda_oe)
    else $error("data pull held too long");
  // shutdown flags follow pin and soft bit
  shut_term_a: assert property (@(posedge mclk) disable iff (!reset_n)
    term_a_open == (!sleep_pin_low || power_down_bit))
    else $error("terminal a state wrong");
  shut_wiper_a: assert property (@(posedge mclk) disable iff (!reset_n) wiper_to_b == term_a_open)
    else $error("wiper short state wrong");
  // taps decode the stored code one cycle later
  tap_one_a: assert property (@(posedge mclk) disable iff (!reset_n)
    tap_sel_one == (256'h1 << $past(wiper_channel_one)))
    else $error("tap one decode wrong");
  tap_two_a: assert property (@(posedge mclk) disable iff (!reset_n)
    tap_sel_two == (256'h1 << $past(wiper_channel_two)))
    else $error("tap two decode wrong");
  reset_mid_a: assert property (@(posedge mclk) !reset_n |=> wiper_channel_one == 8'h80 &&
    wiper_channel_two == 8'h80 && !aux_out_one && !aux_out_two && !power_down_bit)
    else $error("reset values wrong");
  ack_c: cover property (@(posedge link_clk) $rose(sda_oe));
  two_c: cover property (@(posedge mclk) $changed(wiper_channel_two));
  sleep_c: cover property (@(posedge mclk) !sleep_pin_low);
endmodule
bind wpc_slave wpc_monitor #(.NUM_CH(NUM_CH)) mon (.mclk, .reset_n, .link_clk, .scl_in, .sda_in, .sda_out, .sda_oe,
  .addr_pin_low_bit, .addr_pin_high_bit, .sleep_pin_low, .aux_out_one, .aux_out_two, .power_down_bit,
  .wiper_channel_one, .wiper_channel_two, .tap_sel_one, .tap_sel_two, .term_a_open, .wiper_to_b);
`default_nettype wire

// >>> wpc_master.sv
`timescale 1ns/1ps
`default_nettype none
module wpc_master (
  input  wire logic link_clk, // pacing clock
  input  wire logic sda_in,   // resolved data wire
  output var  logic scl,      // serial clock, idle high
  output var  logic sda_low   // high while pulling data low
);
  // bus idles released, clock stands high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // one clock phase, three link cycles
  task automatic hp;
    repeat (3) @(posedge link_clk);
    #1;
  endtask
  // start or repeated start: data falls while clock high
  task automatic start;
    hp;
    sda_low = 1'b0;
    hp;
    scl = 1'b1;
    hp;
    sda_low = 1'b1;
    hp;
    scl = 1'b0;
  endtask
  // stop: data rises while clock high, clock then stands still
  task automatic stop;
    hp;
    sda_low = 1'b1;
    hp;
    scl = 1'b1;
    hp;
    sda_low = 1'b0;
    hp;
  endtask
  // n bits msb first, a one releases the wire; data moves only while clock low
  task automatic xfer(input int n, input logic [8:0] tx, output logic [8:0] rx);
    rx = 9'h1ff;
    for (int i = 8; i > 8 - n; i--) begin
      hp;
      sda_low = !tx[i];
      hp;
      scl = 1'b1;
      hp;
      rx[i] = sda_in;
      scl = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic         mclk = 1'b0;
  logic         link_clk = 1'b0;
  logic         reset_n = 1'b0;
  logic         addr_pin_low_bit = 1'b1;
  logic         addr_pin_high_bit = 1'b0;
  logic         sleep_pin_low = 1'b1;
  logic         scl_in, sda_in, m_low, sda_out, sda_oe, aux_out_one, aux_out_two;
  logic         power_down_bit, term_a_open, wiper_to_b;
  logic [7:0]   wiper_channel_one, wiper_channel_two;
  logic [255:0] tap_sel_one, tap_sel_two;
  logic [8:0]   rx;
  int           n_errors = 0;
  int           compares = 0;
  // open-drain data wire with pull-up
  assign sda_in = !(m_low || (sda_oe && !sda_out));
  initial begin
    forever #2.5 mclk = !mclk;
  end
  initial begin
    #7;
    forever #62.5 link_clk = !link_clk;
  end
  wpc_master M (.link_clk, .sda_in, .scl(scl_in), .sda_low(m_low));
  wpc_slave #(.NUM_CH(2)) DUT (.mclk, .reset_n, .link_clk, .scl_in, .sda_in, .sda_out, .sda_oe, .addr_pin_low_bit,
    .addr_pin_high_bit, .sleep_pin_low, .aux_out_one, .aux_out_two, .power_down_bit, .wiper_channel_one,
    .wiper_channel_two, .tap_sel_one, .tap_sel_two, .term_a_open, .wiper_to_b);
  task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  // address byte from the fixed pattern and the select pins
  function automatic logic [7:0] adr(input logic rd);
    return {wpc_pkg::ADDR_FIXED, addr_pin_high_bit, addr_pin_low_bit, rd};
  endfunction
  // one byte plus ack slot
  task automatic tx(input logic [7:0] b, input logic ack);
    M.xfer(9, {b, 1'b1}, rx);
    chk(rx[0], !ack);
  endtask
  task automatic wr(input logic [7:0] ins, input logic nd, input logic [7:0] d);
    M.start;
    tx(adr(1'b0), 1'b1);
    tx(ins, 1'b1);
    if (nd) begin
      tx(d, 1'b1);
    end
    M.stop;
  endtask
  task automatic rd(input logic [7:0] exp);
    M.start;
    tx(adr(1'b1), 1'b1);
    M.xfer(9, 9'h1ff, rx);
    chk(rx[8:1], exp);
    M.stop;
  endtask
  task automatic t_write;
    chk({wiper_channel_one, wiper_channel_two}, 16'h8080);
    chk(tap_sel_one, 256'h1 << 128);
    M.start;
    tx(adr(1'b0), 1'b1);
    tx(8'h17, 1'b1);
    tx(8'h00, 1'b1);
    M.hp;
    M.hp;
    chk(tap_sel_one, 256'h1);
    tx(8'hff, 1'b1);
    M.stop;
    chk(tap_sel_one, 256'h1 << 255);
    chk({aux_out_one, aux_out_two, wiper_channel_two}, 10'h280);
    $display("t_write done");
  endtask
  task automatic t_chan;
    wr(8'h88, 1'b1, 8'h3c);
    chk({aux_out_one, aux_out_two, wiper_channel_one, wiper_channel_two}, 18'h1ff3c);
    chk(tap_sel_two, 256'h1 << 8'h3c);
    wr(8'hc0, 1'b0, 8'h00);
    chk(wiper_channel_two, 8'h80);
    rd(8'h80);
    wr(8'h00, 1'b0, 8'h00);
    rd(8'hff);
    $display("t_chan done");
  endtask
  task automatic t_addr;
    M.start;
    tx(adr(1'b0) ^ 8'h02, 1'b0);
    M.xfer(9, 9'h001, rx);
    M.stop;
    chk(wiper_channel_one, 8'hff);
    @(posedge mclk);
    #1;
    addr_pin_high_bit = 1'b1;
    addr_pin_low_bit = 1'b0;
    wr(8'h00, 1'b1, 8'h5a);
    chk(wiper_channel_one, 8'h5a);
    M.start;
    tx(adr(1'b1), 1'b1);
    M.xfer(9, 9'h1fe, rx);
    chk(rx[8:1], 8'h5a);
    M.xfer(9, 9'h1ff, rx);
    chk(rx[8:1], 8'h5a);
    M.stop;
    $display("t_addr done");
  endtask
  task automatic t_shut;
    @(posedge mclk);
    #1;
    sleep_pin_low = 1'b0;
    #1;
    chk({term_a_open, wiper_to_b}, 2'h3);
    wr(8'h00, 1'b1, 8'h33);
    chk(wiper_channel_one, 8'h33);
    @(posedge mclk);
    #1;
    sleep_pin_low = 1'b1;
    #1;
    chk({term_a_open, wiper_to_b}, 2'h0);
    chk(tap_sel_one, 256'h1 << 8'h33);
    wr(8'h20, 1'b0, 8'h00);
    chk({power_down_bit, term_a_open, wiper_to_b, wiper_channel_one}, 11'h733);
    wr(8'h00, 1'b0, 8'h00);
    chk({power_down_bit, term_a_open}, 2'h0);
    chk(tap_sel_one, 256'h1 << 8'h33);
    $display("t_shut done");
  endtask
  task automatic t_abort;
    M.start;
    tx(adr(1'b0), 1'b1);
    tx(8'h18, 1'b1);
    M.xfer(4, 9'h000, rx);
    M.stop;
    chk({aux_out_one, aux_out_two, wiper_channel_one}, 10'h333);
    $display("t_abort done");
  endtask
  task automatic complete_run;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge link_clk);
    @(posedge mclk);
    #1;
    reset_n = 1'b1;
    repeat (8) @(posedge link_clk);
    t_write;
    t_chan;
    t_addr;
    t_shut;
    t_abort;
    complete_run;
  end
  initial begin
    #480us;
    n_errors++;
    complete_run;
  end
endmodule
`default_nettype wire
